// >>> vic_vectored_controller.sv
// Vectored interrupt controller: request stage, priority stage, vector stage,
// AXI4-Lite register slave and a daisy-chain input.
// Assumes irq lines and the chain input come from logic on aclk.
//
// Behaviour
// - Single clock aclk, active-low reset aresetn.
// - Up to 32 level-sensitive interrupt inputs.
// - Output stream always valid, ignores back-pressure.
// - Word: handler, register set, nonmaskable, level.
// - Chain input uses same format, same latency as the lines.
// - Register reads answer after one cycle.
// - Source raisable by line or soft trigger.
// - Highest programmed level wins.
// - Level tie goes to lowest index.
// - Level zero means source disabled.
// - Level width is a build parameter.
// - Source count is a build parameter.
// - Handler is index times bytes plus base.
// - Winning chained request keeps its handler, register set and flag.
// - Wider upstream level gets truncated.
// - Request and vector stages take one cycle.
// - Priority delay depends on source count.
// - Disabled source never takes part in selection.
// - Soft trigger ORed before enable applied.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module vic_vectored_controller
   import vic_pkg::*;
#(
   parameter int NUM_SOURCES = 32,
   parameter int LEVEL_WIDTH = 6,
   parameter bit CHAIN_IN    = 1'b0
) (
   // Clock and reset.
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Interrupt source lines.
   input  wire logic [31:0]          irq,
   // Chain input from the preceding controller.
   input  wire logic                 chain_in_valid,
   input  wire logic [WORD_BITS-1:0] chain_in_data,
   // Selected interrupt output stream.
   output logic                      irq_out_valid,
   output logic [WORD_BITS-1:0]      irq_out_data,
   input  wire logic                 irq_out_ready,
   // AXI4-Lite write address and data.
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [ADDR_BITS-1:0] s_axi_awaddr,
   input  wire logic [2:0]           s_axi_awprot,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   // AXI4-Lite write response.
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output logic [1:0]                s_axi_bresp,
   // AXI4-Lite read channels.
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   input  wire logic [ADDR_BITS-1:0] s_axi_araddr,
   input  wire logic [2:0]           s_axi_arprot,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp
);

   localparam int PRIO_DELAY = prio_delay(NUM_SOURCES);

   // Mask of implemented sources; absent sources read zero and ignore writes.
   localparam logic [31:0] SOURCE_MASK = (NUM_SOURCES >= 32) ? 32'hffff_ffff :
                                         32'((64'h1 << NUM_SOURCES) - 64'h1);
   // Levels are stored at full field width, masked to the configured width.
   localparam logic [LEVEL_BITS-1:0] LEVEL_MASK =
      LEVEL_BITS'((7'h1 << LEVEL_WIDTH) - 7'h1);

   typedef struct packed {
      logic [31:0][CONFIG_BITS-1:0]        source_config;
      logic [31:0]                         enable;
      logic [31:0]                         soft_trigger;
      logic [BPV_BITS-1:0]                 bytes_per_vector;
      logic [31:0]                         vector_base;
      logic [31:0]                         raw_status;
      logic [31:0]                         pending;
      vic_cand_type                        chain_req;
      vic_cand_type [MAX_PRIO_DELAY-1:0]   prio_pipe;
      logic                                out_valid;
      logic [WORD_BITS-1:0]                out_data;
      logic                                aw_held;
      logic [5:0]                          aw_index;
      logic                                aw_bad;
      logic                                w_held;
      logic [31:0]                         w_data;
      logic                                w_full;
      logic                                bvalid;
      logic [1:0]                          bresp;
      logic                                rvalid;
      logic [31:0]                         rdata;
      logic [1:0]                          rresp;
   } vic_state_type;

   vic_state_type state;
   vic_state_type next_state;
   vic_cand_type  winner;
   vic_cand_type  delayed;
   logic          do_write;
   logic [5:0]    ar_index;

   // Index of a byte address; out-of-range indices answer with an error.
   function automatic logic [5:0] reg_index(input logic [ADDR_BITS-1:0] addr);
      return addr[7:2];
   endfunction

   function automatic logic index_bad(input logic [ADDR_BITS-1:0] addr);
      return reg_index(addr) > IDX_VECTOR_BASE;
   endfunction

   // Combinational arbitration over the registered pending set and chain request.
   always_comb begin
      winner = '0;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         // Strictly greater keeps the earlier, lower index on a tie.
         if (state.pending[i] &&
             state.source_config[i][LEVEL_BITS-1:0] > winner.level) begin
            winner.level               = state.source_config[i][LEVEL_BITS-1:0];
            winner.index               = 5'(i);
            winner.nonmaskable_flag    = state.source_config[i][NMI_POS];
            winner.register_set_select = state.source_config[i][RSET_LSB +: RSET_BITS];
         end
      end
      // A chained request wins only with a strictly higher level.
      if (CHAIN_IN && state.chain_req.level > winner.level) begin
         winner = state.chain_req;
      end
      // Without a pipeline register the vector stage reads the winner directly.
      delayed = (PRIO_DELAY == 0) ? winner : state.prio_pipe[PRIO_DELAY-1];
   end

   assign ar_index = reg_index(s_axi_araddr);
   assign do_write = state.aw_held && state.w_held && !state.bvalid;

   // Next state: registers, request stage, priority pipe, vector stage and bus.
   always_comb begin
      next_state = state;

      // Request stage: one cycle from line or trigger to pending.
      next_state.raw_status = irq & SOURCE_MASK;
      next_state.pending    = (irq | state.soft_trigger) & state.enable & SOURCE_MASK;
      next_state.chain_req  = '0;
      if (CHAIN_IN && chain_in_valid) begin
         next_state.chain_req.level = chain_in_data[LEVEL_LSB +: LEVEL_BITS] & LEVEL_MASK;
         next_state.chain_req.nonmaskable_flag = chain_in_data[NMI_POS];
         next_state.chain_req.register_set_select = chain_in_data[RSET_LSB +: RSET_BITS];
         next_state.chain_req.chained = 1'b1;
         next_state.chain_req.handler_address = chain_in_data[HANDLER_LSB +: 32];
      end

      // Priority pipeline: a fixed three-stage shift, tapped at a depth that follows the source count.
      next_state.prio_pipe = {state.prio_pipe[MAX_PRIO_DELAY-2:0], winner};

      // Vector stage: one cycle, handler computed for local winners only.
      next_state.out_valid = 1'b1;
      next_state.out_data[LEVEL_LSB +: LEVEL_BITS] = delayed.level;
      next_state.out_data[NMI_POS]                 = delayed.nonmaskable_flag;
      next_state.out_data[RSET_LSB +: RSET_BITS]   = delayed.register_set_select;
      if (delayed.chained) begin
         next_state.out_data[HANDLER_LSB +: 32] = delayed.handler_address;
      end else begin
         // Both factors are widened first so that the product cannot wrap at 16 bits.
         next_state.out_data[HANDLER_LSB +: 32] =
            (32'(delayed.index) * 32'(state.bytes_per_vector)) + state.vector_base;
      end
      // With nothing selected the whole word is zero, so the vector base never leaks out.
      if (delayed.level == '0) begin
         next_state.out_data = '0;
      end

      // Write address and data are caught separately, in either order.
      if (s_axi_awvalid && !state.aw_held) begin
         next_state.aw_held  = 1'b1;
         next_state.aw_index = reg_index(s_axi_awaddr);
         next_state.aw_bad   = index_bad(s_axi_awaddr);
      end
      if (s_axi_wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_full = &s_axi_wstrb;
      end

      // The registers have no byte lanes; a partial write is ignored.
      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = state.aw_bad ? RESP_SLVERR : RESP_OKAY;
         if (state.w_full && !state.aw_bad) begin
            if (state.aw_index <= IDX_SOURCE_CONFIG_LAST) begin
               if (SOURCE_MASK[state.aw_index[4:0]]) begin
                  next_state.source_config[state.aw_index[4:0]] =
                     state.w_data[CONFIG_BITS-1:0] & {7'h7f, LEVEL_MASK};
               end
            end else begin
               case (state.aw_index)
                  IDX_ENABLE:             next_state.enable = state.w_data & SOURCE_MASK;
                  IDX_ENABLE_SET:         next_state.enable = state.enable |
                                                              (state.w_data & SOURCE_MASK);
                  IDX_ENABLE_CLEAR:       next_state.enable = state.enable & ~state.w_data;
                  IDX_SOFT_TRIGGER:       next_state.soft_trigger = state.w_data & SOURCE_MASK;
                  IDX_SOFT_TRIGGER_SET:   next_state.soft_trigger = state.soft_trigger |
                                                                    (state.w_data & SOURCE_MASK);
                  IDX_SOFT_TRIGGER_CLEAR: next_state.soft_trigger = state.soft_trigger &
                                                                    ~state.w_data;
                  IDX_GLOBAL_CONFIG:      next_state.bytes_per_vector = state.w_data[BPV_BITS-1:0];
                  IDX_VECTOR_BASE:        next_state.vector_base = state.w_data;
                  default:                next_state.bresp = RESP_OKAY;
               endcase
            end
         end
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end

      // Reads are taken when no answer is outstanding and answer one cycle later.
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp  = index_bad(s_axi_araddr) ? RESP_SLVERR : RESP_OKAY;
         next_state.rdata  = RESET_WORD;
         if (ar_index <= IDX_SOURCE_CONFIG_LAST) begin
            next_state.rdata = SOURCE_MASK[ar_index[4:0]] ?
                               32'(state.source_config[ar_index[4:0]]) : RESET_WORD;
         end else begin
            case (ar_index)
               IDX_ENABLE:        next_state.rdata = state.enable;
               IDX_PENDING:       next_state.rdata = state.pending;
               IDX_RAW_STATUS:    next_state.rdata = state.raw_status;
               IDX_SOFT_TRIGGER:  next_state.rdata = state.soft_trigger;
               IDX_GLOBAL_CONFIG: next_state.rdata = 32'(state.bytes_per_vector);
               IDX_VECTOR_BASE:   next_state.rdata = state.vector_base;
               default:           next_state.rdata = RESET_WORD;
            endcase
         end
      end
   end

   // One register for all state; reset clears every field.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // The stream has no back-pressure, so irq_out_ready is deliberately unused.
   assign irq_out_valid = state.out_valid;
   assign irq_out_data  = state.out_data;

   // Bus handshakes follow the holding flags.
   assign s_axi_awready = !state.aw_held;
   assign s_axi_wready  = !state.w_held;
   assign s_axi_bvalid  = state.bvalid;
   assign s_axi_bresp   = state.bresp;
   assign s_axi_arready = !state.rvalid;
   assign s_axi_rvalid  = state.rvalid;
   assign s_axi_rdata   = state.rdata;
   assign s_axi_rresp   = state.rresp;

endmodule // vic_vectored_controller

// >>> vic_pkg.sv
// Package for the vectored interrupt controller: register indices, field layout,
// stream word layout, reset values and latency helpers.
// Assumes a 32-bit register bus where each register takes one aligned word.
package vic_pkg;

   // Sizes of the source array and the fields.
   localparam int MAX_SOURCES   = 32;
   localparam int LEVEL_BITS    = 6;
   localparam int RSET_BITS     = 6;
   localparam int WORD_BITS     = 45;
   localparam int ADDR_BITS     = 8;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_SOURCE_CONFIG_LAST = 6'h1f;
   localparam logic [5:0] IDX_ENABLE             = 6'h20;
   localparam logic [5:0] IDX_ENABLE_SET         = 6'h21;
   localparam logic [5:0] IDX_ENABLE_CLEAR       = 6'h22;
   localparam logic [5:0] IDX_PENDING            = 6'h23;
   localparam logic [5:0] IDX_RAW_STATUS         = 6'h24;
   localparam logic [5:0] IDX_SOFT_TRIGGER       = 6'h25;
   localparam logic [5:0] IDX_SOFT_TRIGGER_SET   = 6'h26;
   localparam logic [5:0] IDX_SOFT_TRIGGER_CLEAR = 6'h27;
   localparam logic [5:0] IDX_GLOBAL_CONFIG      = 6'h28;
   localparam logic [5:0] IDX_VECTOR_BASE        = 6'h29;

   // Field positions inside a source configuration word and the stream word.
   localparam int LEVEL_LSB   = 0;
   localparam int NMI_POS     = 6;
   localparam int RSET_LSB    = 7;
   localparam int HANDLER_LSB = 13;
   localparam int CONFIG_BITS = 13;
   localparam int BPV_BITS    = 16;

   // Reset value and bus response codes.
   localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // Fixed stage delays in cycles.
   localparam int REQUEST_DELAY = 1;
   localparam int VECTOR_DELAY  = 1;
   localparam int MAX_PRIO_DELAY = 3;

   // Priority stage delay as a function of the number of sources.
   function automatic int prio_delay(input int n);
      if (n <= 1) begin
         return 0;
      end else if (n <= 4) begin
         return 1;
      end else if (n <= 16) begin
         return 2;
      end
      return 3;
   endfunction

   // One arbitration candidate travelling through the priority stage.
   typedef struct packed {
      logic [LEVEL_BITS-1:0] level;
      logic [4:0]            index;
      logic                  nonmaskable_flag;
      logic [RSET_BITS-1:0]  register_set_select;
      logic                  chained;
      logic [31:0]           handler_address;
   } vic_cand_type;

endpackage

// >>> vic_asserts.sv
// Port-level checks for the vectored interrupt controller.
// Assumes it is bound into vic_vectored_controller and sees only its ports.
`timescale 1ns/1ps

module vic_asserts
   import vic_pkg::*;
#(
   parameter int NUM_SOURCES = 32,
   parameter int LEVEL_WIDTH = 6,
   parameter bit CHAIN_IN    = 1'b0
) (
   // Clock, reset and interrupt side.
   input wire logic                 aclk, aresetn, chain_in_valid, irq_out_valid,
   input wire logic [31:0]          irq,
   input wire logic [WORD_BITS-1:0] chain_in_data, irq_out_data,
   // Register bus side.
   input wire logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic                 s_axi_rvalid, s_axi_rready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic [31:0]          s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] quiet_cnt;

   // Cycles without input change or register write; a write may retune any source.
   always_ff @(posedge aclk) begin
      if (!aresetn || !$stable(irq) || !$stable(chain_in_data) || !$stable(chain_in_valid)
          || (s_axi_wvalid && s_axi_wready))
         quiet_cnt <= 4'h0;
      else if (quiet_cnt != 4'hf)
         quiet_cnt <= quiet_cnt + 4'h1;
   end

   a_valid_always: assert property ($past(aresetn) |-> irq_out_valid)
      else $error("stream output not valid");
   a_idle_zero: assert property (irq_out_data[5:0] == 6'h00 |-> irq_out_data == '0)
      else $error("level zero word carries data");
   a_level_width: assert property (int'(irq_out_data[5:0]) < (1 << LEVEL_WIDTH))
      else $error("level wider than configured");
   a_output_steady: assert property (quiet_cnt >= 4'ha |-> $stable(irq_out_data))
      else $error("output changed without cause");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer timing");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");

   // Main scenarios.
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_nmi_word: cover property (irq_out_data[6] && irq_out_data[5:0] != 6'h00);
endmodule // vic_asserts

bind vic_vectored_controller vic_asserts #(.NUM_SOURCES(NUM_SOURCES),
   .LEVEL_WIDTH(LEVEL_WIDTH), .CHAIN_IN(CHAIN_IN)) i_vic_asserts (.*);

// >>> vic_partner.sv
// Model of the processor interrupt port that takes the selected-interrupt stream.
// Assumes the controller's stream is registered on aclk.
`timescale 1ns/1ps

module vic_partner
   import vic_pkg::*;
(
   // Clock and reset.
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Stream from the controller.
   input  wire logic                 in_valid,
   input  wire logic [WORD_BITS-1:0] in_data,
   output logic                      in_ready,
   output logic [WORD_BITS-1:0]      last_word
);
   // Ready toggles every cycle so that any dependence on back-pressure shows up.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_ready  <= 1'b0;
         last_word <= '0;
      end else begin
         in_ready <= ~in_ready;
         if (in_valid)
            last_word <= in_data;
      end
   end
endmodule // vic_partner

// >>> tb_top.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes a five-bit level build with the chain input present.
`timescale 1ns/1ps

module tb_top;
   import vic_pkg::*;
   logic        aclk, aresetn, chain_in_valid, irq_out_valid, irq_out_ready;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [1:0]  bresp, rresp;
   logic [31:0] irq, wdata, rdata, base, noise, ch;
   logic [3:0]  wstrb;
   logic [44:0] chain_in_data, irq_out_data, exp_w[$];
   logic [33:0] exp_rd[$];
   logic [1:0]  exp_b[$];
   int          err_total, samples_checked;
   event        word_evt;

   vic_vectored_controller #(.NUM_SOURCES(32), .LEVEL_WIDTH(5), .CHAIN_IN(1'b1))
   i_vic_vectored_controller (.aclk(aclk), .aresetn(aresetn), .irq(irq),
      .chain_in_valid(chain_in_valid), .chain_in_data(chain_in_data),
      .irq_out_valid(irq_out_valid), .irq_out_data(irq_out_data), .irq_out_ready(irq_out_ready),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp));

   vic_partner i_vic_partner (.aclk(aclk), .aresetn(aresetn), .in_valid(irq_out_valid),
      .in_data(irq_out_data), .in_ready(irq_out_ready), .last_word());

   // 100 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected read at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected bresp at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_word(input logic [44:0] e, input logic [44:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected word at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   // Answers are taken at the edge where they are accepted, oldest note first.
   always @(posedge aclk) begin
      if (rvalid && rready)
         cmp_rd(exp_rd.pop_front(), {rresp, rdata});
      if (bvalid && bready)
         cmp_b(exp_b.pop_front(), bresp);
   end

   // Stream words are judged when the driver says the result is due.
   always @(word_evt) begin
      cmp_word(exp_w.pop_front(), irq_out_data);
   end

   // Each channel is released on the edge that takes it; the answer ends the task.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      #1;
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      #1;
      exp_rd.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask

   task automatic chk(input logic [44:0] w);
      exp_w.push_back(w);
      -> word_evt;
   endtask

   task automatic settle(input logic [44:0] w);
      repeat (8) @(posedge aclk);
      #1 chk(w);
   endtask

   // Handler is index times 0x20 plus the programmed base.
   function automatic logic [44:0] word_of(int i, logic [5:0] l, logic n, logic [5:0] s);
      return {32'(i) * 32'h20 + base, s, n, l};
   endfunction

   task automatic stop_test;
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog, far beyond the roughly 140 cycles the sequence needs.
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      stop_test();
   end

   initial begin
      void'($urandom(32'h10c6));
      {aresetn, chain_in_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
      {irq, awaddr, araddr, wdata, chain_in_data, err_total, samples_checked} = '0;
      wstrb = 4'hf;
      base = $urandom & 32'hffff_ff00;
      noise = $urandom & ~32'h1288;
      ch = $urandom;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (exp_b[i]) ;
      axi_read(8'h0c, 32'h0, RESP_OKAY);
      axi_read(8'h80, 32'h0, RESP_OKAY);
      axi_read(8'ha4, 32'h0, RESP_OKAY);
      axi_write(8'ha0, 32'h20, RESP_OKAY);
      axi_write(8'ha4, base, RESP_OKAY);
      axi_write(8'h0c, {19'h0, 6'h2, 1'b1, 6'h05}, RESP_OKAY);
      axi_write(8'h1c, {19'h0, 6'h1, 1'b0, 6'h05}, RESP_OKAY);
      axi_write(8'h24, $urandom & 32'h1fc0, RESP_OKAY);
      axi_write(8'h30, {19'h0, 6'h3, 1'b0, 6'h09}, RESP_OKAY);
      axi_write(8'h84, 32'h1288, RESP_OKAY);
      axi_read(8'h80, 32'h1288, RESP_OKAY);
      axi_read(8'h84, 32'h0, RESP_OKAY);
      // A write without all byte lanes must leave the register untouched.
      wstrb <= 4'h3;
      axi_write(8'ha4, ~base, RESP_OKAY);
      wstrb <= 4'hf;
      axi_read(8'ha4, base, RESP_OKAY);
      @(posedge aclk);
      irq <= 32'h0208 | noise;
      repeat (4) @(posedge aclk);
      #1 chk('0);
      @(posedge aclk);
      #1 chk(word_of(3, 6'h05, 1'b1, 6'h2));
      irq <= irq | 32'h80;
      settle(word_of(3, 6'h05, 1'b1, 6'h2));
      irq <= irq | 32'h1000;
      settle(word_of(12, 6'h09, 1'b0, 6'h3));
      axi_write(8'h88, 32'h1000, RESP_OKAY);
      settle(word_of(3, 6'h05, 1'b1, 6'h2));
      axi_read(8'h8c, 32'h0288, RESP_OKAY);
      axi_read(8'h90, irq, RESP_OKAY);
      irq <= noise;
      axi_write(8'h98, 32'h80, RESP_OKAY);
      settle(word_of(7, 6'h05, 1'b0, 6'h1));
      axi_write(8'h88, 32'h80, RESP_OKAY);
      settle('0);
      axi_read(8'h94, 32'h80, RESP_OKAY);
      irq <= 32'h8 | noise;
      chain_in_valid <= 1'b1;
      chain_in_data <= {ch, 6'h2a, 1'b1, 6'h26};
      settle({ch, 6'h2a, 1'b1, 6'h06});
      chain_in_data <= {ch, 6'h2a, 1'b1, 6'h25};
      settle(word_of(3, 6'h05, 1'b1, 6'h2));
      chain_in_valid <= 1'b0;
      axi_read(8'ha8, 32'h0, RESP_SLVERR);
      axi_write(8'hac, 32'hffff_ffff, RESP_SLVERR);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle('0);
      axi_read(8'h0c, 32'h0, RESP_OKAY);
      stop_test();
   end
endmodule // tb_top
